// ---- pkg/dpt_pkg.sv ----
`default_nettype none
package dpt_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] DPT_ADDR_AUTO_BW = 8'h3B;
   localparam int DPT_AUTO_BW_BIT = 7;
   localparam logic [7:0] DPT_ADDR_LOCKED_BW = 8'h67;
   localparam logic [7:0] DPT_ADDR_ACQ_BW = 8'h69;
   localparam logic [7:0] DPT_ADDR_DAMPING = 8'h6B;
   localparam logic [7:0] DPT_ADDR_TRIM_LO = 8'h7C;
   localparam logic [7:0] DPT_ADDR_TRIM_HI = 8'h7D;
   localparam logic [7:0] DPT_ADDR_STATUS = 8'h7E;

   // ----------------------------------------
   // field layouts
   // ----------------------------------------
   localparam int DPT_BW_W = 5;
   localparam int DPT_DCODE_W = 3;
   localparam int DPT_STAT_BW_LSB = 0;
   localparam int DPT_STAT_DAMP_LSB = 5;

   // ----------------------------------------
   // bandwidth step codes
   // ----------------------------------------
   localparam logic [4:0] DPT_BW_4HZ = 5'h0D;
   localparam logic [4:0] DPT_BW_8HZ = 5'h0E;
   localparam logic [4:0] DPT_BW_18HZ = 5'h0F;
   localparam logic [4:0] DPT_BW_35HZ = 5'h10;
   localparam logic [4:0] DPT_BW_70HZ = 5'h11;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [4:0] DPT_LOCKED_BW_RST = 5'h0D;
   localparam logic [4:0] DPT_ACQ_BW_RST = 5'h11;
   localparam logic [2:0] DPT_DCODE_RST = 3'h3;
   localparam logic [2:0] DPT_DCODE_MIN = 3'h1;
   localparam logic [2:0] DPT_DCODE_MAX = 3'h5;
   localparam logic DPT_AUTO_BW_RST = 1'b0;
   localparam logic [15:0] DPT_TRIM_RST = 16'h9999;

   // ----------------------------------------
   // timing and trim arithmetic
   // ----------------------------------------
   localparam int DPT_MASTER_CLK_HZ = 12800000;
   localparam real DPT_TRIM_STEP_PPM = 0.0196229;
   localparam int DPT_TRIM_SHIFT = 40;
   localparam int DPT_TRIM_GAIN_I =
      int'(DPT_TRIM_STEP_PPM * 1.0E-6 * (2.0 ** DPT_TRIM_SHIFT));
   localparam logic [15:0] DPT_TRIM_GAIN = DPT_TRIM_GAIN_I[15:0];

   // ----------------------------------------
   // damping factors
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPT_DAMP_1P2 = 3'b000,
      DPT_DAMP_2P5 = 3'b001,
      DPT_DAMP_5 = 3'b010,
      DPT_DAMP_10 = 3'b011,
      DPT_DAMP_20 = 3'b100
   } dpt_damp_type;

   // damping factor times ten
   function automatic logic [7:0] dpt_damp_x10(input dpt_damp_type d);
      logic [7:0] v;
      v = 8'h32;
      unique case (d)
         DPT_DAMP_1P2: v = 8'h0C;
         DPT_DAMP_2P5: v = 8'h19;
         DPT_DAMP_5: v = 8'h32;
         DPT_DAMP_10: v = 8'h64;
         DPT_DAMP_20: v = 8'hC8;
         default: v = 8'h32;
      endcase
      return v;
   endfunction
endpackage
`default_nettype wire

// ---- core/dpt_damp_map.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpt_damp_map
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // selection
   input wire logic [4:0] bw_i,
   input wire logic [2:0] code_i,
   // result
   output dpt_pkg::dpt_damp_type damp_o
);
   // ----------------------------------------
   // code and bandwidth to factor
   // ----------------------------------------
   function automatic dpt_pkg::dpt_damp_type map(input logic [4:0] bw, input logic [2:0] c);
      dpt_pkg::dpt_damp_type d;
      d = dpt_pkg::DPT_DAMP_5;
      if (c < dpt_pkg::DPT_DCODE_MIN || c > dpt_pkg::DPT_DCODE_MAX)
         d = dpt_pkg::DPT_DAMP_5;
      else if (bw <= dpt_pkg::DPT_BW_4HZ)
         d = dpt_pkg::DPT_DAMP_5;
      else if (bw == dpt_pkg::DPT_BW_8HZ)
         d = (c == 3'h1) ? dpt_pkg::DPT_DAMP_2P5 : dpt_pkg::DPT_DAMP_5;
      else if (bw == dpt_pkg::DPT_BW_18HZ)
      begin
         if (c == 3'h1)
            d = dpt_pkg::DPT_DAMP_1P2;
         else if (c == 3'h2)
            d = dpt_pkg::DPT_DAMP_2P5;
         else
            d = dpt_pkg::DPT_DAMP_5;
      end
      else if (bw == dpt_pkg::DPT_BW_35HZ)
      begin
         if (c >= 3'h4)
            d = dpt_pkg::DPT_DAMP_10;
         else
            d = dpt_pkg::dpt_damp_type'(c - 3'h1);
      end
      else
         d = dpt_pkg::dpt_damp_type'(c - 3'h1);
      return d;
   endfunction

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         damp_o <= dpt_pkg::DPT_DAMP_5;
      else
         damp_o <= map(bw_i, code_i);
   end
endmodule // dpt_damp_map
`default_nettype wire

// ---- core/dpt_freq_scale.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpt_freq_scale
#(
   parameter int FREQ_W = 32
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // operands
   input wire logic [FREQ_W-1:0] base_i,
   input wire logic [15:0] trim_i,
   // result
   output logic [FREQ_W-1:0] scaled_o
);
   localparam int PROD_W = FREQ_W + 34;

   if (FREQ_W < 8 || FREQ_W > 48)
      $error("dpt_freq_scale: FREQ_W out of range");

   logic signed [16:0] delta;
   logic signed [31:0] step_r;
   logic [FREQ_W-1:0] base_r;
   logic signed [PROD_W-1:0] prod;
   logic signed [PROD_W-1:0] sum;

   // ----------------------------------------
   // signed offset from the zero point
   // ----------------------------------------
   assign delta = $signed({1'b0, trim_i}) - $signed({1'b0, dpt_pkg::DPT_TRIM_RST});

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         step_r <= 32'sh00000000;
         base_r <= '0;
      end
      else
      begin
         step_r <= $signed({{15{delta[16]}}, delta}) *
                   $signed({16'h0000, dpt_pkg::DPT_TRIM_GAIN});
         base_r <= base_i;
      end
   end

   // ----------------------------------------
   // common relative scaling
   // ----------------------------------------
   assign prod = $signed({{(PROD_W-FREQ_W){1'b0}}, base_r}) *
                 $signed({{(PROD_W-32){step_r[31]}}, step_r});
   assign sum = $signed({{(PROD_W-FREQ_W){1'b0}}, base_r}) +
                (prod >>> dpt_pkg::DPT_TRIM_SHIFT);

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         scaled_o <= '0;
      else if (sum[PROD_W-1])
         scaled_o <= '0;
      else if (|sum[PROD_W-2:FREQ_W])
         scaled_o <= '1;
      else
         scaled_o <= sum[FREQ_W-1:0];
   end
endmodule // dpt_freq_scale
`default_nettype wire

// ---- core/dpt_trim_top.sv ----
// How it works
// - A 3-bit damping code of 1 to 5 is turned into a damping factor from code and bandwidth.
// - From 0.5 mHz up to 4 Hz bandwidth the damping factor is 5 for every legal code.
// - At 8 Hz code 1 gives 2.5 and others 5; at 18 Hz codes give 1.2, 2.5, then 5.
// - At 35 Hz codes give 1.2, 2.5, 5, then 10; at 70 Hz they give 1.2, 2.5, 5, 10, 20.
// - After reset the damping selection gives factor 5, about 0.1 dB of gain peak.
// - The trim is one 16-bit unsigned value in two 8-bit locations, both readable and writable.
// - Each trim step up raises all output frequencies by 0.0196229 ppm, and down lowers them.
// - Reset loads the trim with 39321 (hex 9999), which means zero frequency offset.
// - Any trim from 0 to 65535 is accepted, spanning -771 ppm to +514 ppm.
// - The loop acts as a low-pass on input phase with its pole set by the bandwidth in use.
// - With automatic bandwidth on, acquire bandwidth is used while unlocked, else locked one.
`timescale 1ns/10ps
`default_nettype none
module dpt_trim_top
#(
   parameter int FREQ_W = 32
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   // loop status and frequency word
   input wire logic dpll_locked_i,
   input wire logic [FREQ_W-1:0] nco_freq_i,
   // loop settings
   output logic [4:0] active_bw_o,
   output dpt_pkg::dpt_damp_type damping_o,
   output logic [7:0] damping_x10_o,
   output logic [15:0] trim_o,
   output logic [FREQ_W-1:0] scaled_freq_o
);
   if (FREQ_W < 8 || FREQ_W > 48)
      $error("dpt_trim_top: FREQ_W out of range");

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic auto_bw_r;
   logic [4:0] locked_bw_r;
   logic [4:0] acq_bw_r;
   logic [2:0] dcode_r;
   logic [15:0] trim_r;
   logic [4:0] bw_nxt;
   logic [4:0] bw_r;
   logic [7:0] rdata_nxt;
   logic [7:0] rdata_r;
   dpt_pkg::dpt_damp_type damp;

   // clip a bandwidth step code to the top step
   function automatic logic [4:0] bw_clip(input logic [4:0] b);
      return (b > dpt_pkg::DPT_BW_70HZ) ? dpt_pkg::DPT_BW_70HZ : b;
   endfunction

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         auto_bw_r <= dpt_pkg::DPT_AUTO_BW_RST;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_AUTO_BW)
         auto_bw_r <= wdata_i[dpt_pkg::DPT_AUTO_BW_BIT];
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         locked_bw_r <= dpt_pkg::DPT_LOCKED_BW_RST;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_LOCKED_BW)
         locked_bw_r <= wdata_i[dpt_pkg::DPT_BW_W-1:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         acq_bw_r <= dpt_pkg::DPT_ACQ_BW_RST;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_ACQ_BW)
         acq_bw_r <= wdata_i[dpt_pkg::DPT_BW_W-1:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         dcode_r <= dpt_pkg::DPT_DCODE_RST;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_DAMPING)
         dcode_r <= wdata_i[dpt_pkg::DPT_DCODE_W-1:0];
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         trim_r <= dpt_pkg::DPT_TRIM_RST;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_TRIM_LO)
         trim_r[7:0] <= wdata_i;
      else if (we_i && addr_i == dpt_pkg::DPT_ADDR_TRIM_HI)
         trim_r[15:8] <= wdata_i;
   end

   // ----------------------------------------
   // bandwidth in use
   // ----------------------------------------
   always_comb
   begin
      if (auto_bw_r && !dpll_locked_i)
         bw_nxt = bw_clip(acq_bw_r);
      else
         bw_nxt = bw_clip(locked_bw_r);
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         bw_r <= dpt_pkg::DPT_LOCKED_BW_RST;
      else
         bw_r <= bw_nxt;
   end

   // ----------------------------------------
   // damping and trim datapaths
   // ----------------------------------------
   dpt_damp_map u_damp
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .bw_i(bw_r),
      .code_i(dcode_r),
      .damp_o(damp)
   );

   dpt_freq_scale #(.FREQ_W(FREQ_W)) u_scale
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .base_i(nco_freq_i),
      .trim_i(trim_r),
      .scaled_o(scaled_freq_o)
   );

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         damping_x10_o <= 8'h32;
      else
         damping_x10_o <= dpt_pkg::dpt_damp_x10(damp);
   end

   assign damping_o = damp;
   assign active_bw_o = bw_r;
   assign trim_o = trim_r;

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (re_i)
      begin
         unique case (addr_i)
            dpt_pkg::DPT_ADDR_AUTO_BW:
               rdata_nxt[dpt_pkg::DPT_AUTO_BW_BIT] = auto_bw_r;
            dpt_pkg::DPT_ADDR_LOCKED_BW:
               rdata_nxt[dpt_pkg::DPT_BW_W-1:0] = locked_bw_r;
            dpt_pkg::DPT_ADDR_ACQ_BW:
               rdata_nxt[dpt_pkg::DPT_BW_W-1:0] = acq_bw_r;
            dpt_pkg::DPT_ADDR_DAMPING:
               rdata_nxt[dpt_pkg::DPT_DCODE_W-1:0] = dcode_r;
            dpt_pkg::DPT_ADDR_TRIM_LO:
               rdata_nxt = trim_r[7:0];
            dpt_pkg::DPT_ADDR_TRIM_HI:
               rdata_nxt = trim_r[15:8];
            dpt_pkg::DPT_ADDR_STATUS:
               rdata_nxt = {damp, bw_r};
            default:
               rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   assign rdata_o = rdata_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   property p_damp_low_bw;
      bw_r <= dpt_pkg::DPT_BW_4HZ |=> damping_o == dpt_pkg::DPT_DAMP_5;
   endproperty
   a_damp_low_bw: assert property (p_damp_low_bw)
      else $error("damping not 5 at low bandwidth");

   property p_damp_8hz;
      bw_r == dpt_pkg::DPT_BW_8HZ && dcode_r == 3'h1 |=> damping_o == dpt_pkg::DPT_DAMP_2P5;
   endproperty
   a_damp_8hz: assert property (p_damp_8hz)
      else $error("damping wrong at 8 Hz code 1");

   property p_damp_18hz;
      bw_r == dpt_pkg::DPT_BW_18HZ && dcode_r == 3'h2 |=> damping_o == dpt_pkg::DPT_DAMP_2P5;
   endproperty
   a_damp_18hz: assert property (p_damp_18hz)
      else $error("damping wrong at 18 Hz code 2");

   property p_damp_35hz;
      bw_r == dpt_pkg::DPT_BW_35HZ && dcode_r == 3'h5 |=> damping_o == dpt_pkg::DPT_DAMP_10;
   endproperty
   a_damp_35hz: assert property (p_damp_35hz)
      else $error("damping wrong at 35 Hz code 5");

   property p_damp_70hz;
      bw_r == dpt_pkg::DPT_BW_70HZ && dcode_r == 3'h5 |=> damping_o == dpt_pkg::DPT_DAMP_20 ##1
         damping_x10_o == 8'hC8;
   endproperty
   a_damp_70hz: assert property (p_damp_70hz)
      else $error("damping wrong at 70 Hz code 5");

   property p_damp_code;
      $changed(dcode_r) && $stable(bw_r) ##1 $stable(bw_r) |-> $changed(damping_o) ||
         (bw_r <= dpt_pkg::DPT_BW_4HZ) || dcode_r > 3'h1 || $past(dcode_r, 1) > 3'h1;
   endproperty
   a_damp_code: assert property (p_damp_code)
      else $error("damping did not follow code");

   property p_reset_damp;
      $past(!resetn_i) |-> dcode_r == dpt_pkg::DPT_DCODE_RST && damping_o == dpt_pkg::DPT_DAMP_5;
   endproperty
   a_reset_damp: assert property (p_reset_damp)
      else $error("damping not 5 after reset");

   property p_bw_auto;
      auto_bw_r && !dpll_locked_i |=> active_bw_o == bw_clip($past(acq_bw_r));
   endproperty
   a_bw_auto: assert property (p_bw_auto)
      else $error("acquire bandwidth not used while unlocked");

   property p_bw_locked;
      !auto_bw_r || dpll_locked_i |=> active_bw_o == bw_clip($past(locked_bw_r));
   endproperty
   a_bw_locked: assert property (p_bw_locked)
      else $error("locked bandwidth not used");

   property p_trim_write;
      we_i && addr_i == dpt_pkg::DPT_ADDR_TRIM_HI ##1 !we_i ##1
         re_i && addr_i == dpt_pkg::DPT_ADDR_TRIM_HI |=> rdata_o == $past(wdata_i, 3);
   endproperty
   a_trim_write: assert property (p_trim_write)
      else $error("trim high byte readback wrong");

   property p_trim_reset;
      $past(!resetn_i) |-> trim_o == dpt_pkg::DPT_TRIM_RST;
   endproperty
   a_trim_reset: assert property (p_trim_reset)
      else $error("trim not 9999 after reset");

   property p_trim_zero;
      $past(trim_r, 2) == dpt_pkg::DPT_TRIM_RST && $past(resetn_i, 2)
         |-> scaled_freq_o == $past(nco_freq_i, 2);
   endproperty
   a_trim_zero: assert property (p_trim_zero)
      else $error("zero trim changed the frequency");

   property p_trim_lower;
      $past(trim_r, 2) < dpt_pkg::DPT_TRIM_RST && $past(nco_freq_i, 2) != '0 &&
         $past(resetn_i, 2) |-> scaled_freq_o < $past(nco_freq_i, 2);
   endproperty
   a_trim_lower: assert property (p_trim_lower)
      else $error("low trim did not lower the frequency");

   c_auto_switch: cover property (auto_bw_r && !dpll_locked_i ##1 dpll_locked_i);
   c_damp_20: cover property (damping_o == dpt_pkg::DPT_DAMP_20);
   c_trim_min: cover property (trim_r == 16'h0000);
   c_trim_max: cover property (trim_r == 16'hFFFF);
endmodule // dpt_trim_top
`default_nettype wire

// ---- bench/dpll_damping_and_freq_trim_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpll_damping_and_freq_trim_test;
   // ----------------------------------------
   // clock, reset and ports
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic [7:0] rdata_o;
   logic dpll_locked_i = 1'b0;
   logic [31:0] nco_freq_i = 32'h80000000;
   logic [4:0] active_bw_o;
   dpt_pkg::dpt_damp_type damping_o;
   logic [7:0] damping_x10_o;
   logic [15:0] trim_o;
   logic [31:0] scaled_freq_o;
   int fails = 0;
   int checks = 0;
   // damping per bandwidth, codes 1..5 from the low end
   localparam logic [14:0] DTAB [6] = '{15'o22222, 15'o22222, 15'o22221,
      15'o22210, 15'o33210, 15'o43210};
   localparam logic [4:0] BWS [6] = '{5'h00, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11};
   localparam logic [7:0] X10 [5] = '{8'h0C, 8'h19, 8'h32, 8'h64, 8'hC8};
   localparam logic [15:0] TRIMS [5] = '{16'h9999, 16'h999A, 16'h9D81, 16'h0000, 16'hFFFF};

   dpt_trim_top #(.FREQ_W(32)) dut_u
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .we_i(we_i),
      .re_i(re_i),
      .rdata_o(rdata_o),
      .dpll_locked_i(dpll_locked_i),
      .nco_freq_i(nco_freq_i),
      .active_bw_o(active_bw_o),
      .damping_o(damping_o),
      .damping_x10_o(damping_x10_o),
      .trim_o(trim_o),
      .scaled_freq_o(scaled_freq_o)
   );

   initial
   begin
      forever #10 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      chk(32'(rdata_o), 32'(exp));
   endtask

   function automatic logic [31:0] exp_scaled(input logic [31:0] base, input logic [15:0] t);
      longint p;
      p = longint'(base) * (longint'(t) - 39321) * longint'(dpt_pkg::DPT_TRIM_GAIN);
      p = (p >>> 40) + longint'(base);
      if (p < 0)
      begin
         p = 0;
      end
      if (p > 64'hFFFFFFFF)
      begin
         p = 64'hFFFFFFFF;
      end
      return p[31:0];
   endfunction

   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      idle(2);
      chk(32'(damping_o), 32'h2);
      chk(32'(damping_x10_o), 32'h32);
      chk(32'(trim_o), 32'h9999);
      chk(32'(active_bw_o), 32'h0D);
      rd(dpt_pkg::DPT_ADDR_DAMPING, 8'h03);
      rd(dpt_pkg::DPT_ADDR_TRIM_LO, 8'h99);
      rd(dpt_pkg::DPT_ADDR_TRIM_HI, 8'h99);
      rd(dpt_pkg::DPT_ADDR_AUTO_BW, 8'h00);
      rd(dpt_pkg::DPT_ADDR_STATUS, 8'h4D);
      idle(1);
      chk(32'(rdata_o), 32'h0);
      $display("test reset values done");

      for (int b = 0; b < 6; b++)
      begin
         wr(dpt_pkg::DPT_ADDR_LOCKED_BW, {3'h0, BWS[b]});
         for (int c = 1; c <= 5; c++)
         begin
            wr(dpt_pkg::DPT_ADDR_DAMPING, 8'(c));
            idle(4);
            chk(32'(damping_o), 32'(DTAB[b][3*(c-1) +: 3]));
            chk(32'(damping_x10_o), 32'(X10[DTAB[b][3*(c-1) +: 3]]));
            rd(dpt_pkg::DPT_ADDR_STATUS, {DTAB[b][3*(c-1) +: 3], BWS[b]});
         end
      end
      $display("test damping table done");

      wr(dpt_pkg::DPT_ADDR_LOCKED_BW, 8'h10);
      wr(dpt_pkg::DPT_ADDR_DAMPING, 8'h05);
      wr(dpt_pkg::DPT_ADDR_ACQ_BW, 8'h11);
      wr(dpt_pkg::DPT_ADDR_AUTO_BW, 8'h80);
      idle(4);
      chk(32'(active_bw_o), 32'h11);
      chk(32'(damping_o), 32'h4);
      @(posedge clk_i);
      dpll_locked_i <= 1'b1;
      idle(4);
      chk(32'(active_bw_o), 32'h10);
      chk(32'(damping_o), 32'h3);
      rd(dpt_pkg::DPT_ADDR_AUTO_BW, 8'h80);
      wr(dpt_pkg::DPT_ADDR_AUTO_BW, 8'h00);
      dpll_locked_i <= 1'b0;
      idle(4);
      chk(32'(active_bw_o), 32'h10);
      $display("test automatic bandwidth done");

      for (int i = 0; i < 5; i++)
      begin
         wr(dpt_pkg::DPT_ADDR_TRIM_LO, TRIMS[i][7:0]);
         wr(dpt_pkg::DPT_ADDR_TRIM_HI, TRIMS[i][15:8]);
         idle(4);
         chk(32'(trim_o), 32'(TRIMS[i]));
         chk(scaled_freq_o, exp_scaled(nco_freq_i, TRIMS[i]));
         rd(dpt_pkg::DPT_ADDR_TRIM_LO, TRIMS[i][7:0]);
         rd(dpt_pkg::DPT_ADDR_TRIM_HI, TRIMS[i][15:8]);
      end
      chk(exp_scaled(32'h80000000, 16'h999A), 32'h8000002A);
      @(posedge clk_i);
      nco_freq_i <= 32'h12345678;
      idle(4);
      chk(scaled_freq_o, exp_scaled(32'h12345678, 16'hFFFF));
      wr(dpt_pkg::DPT_ADDR_TRIM_LO, 8'h99);
      wr(dpt_pkg::DPT_ADDR_TRIM_HI, 8'h99);
      rd(dpt_pkg::DPT_ADDR_TRIM_HI, 8'h99);
      idle(4);
      chk(scaled_freq_o, 32'h12345678);
      $display("test frequency trim done");

      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      wr(dpt_pkg::DPT_ADDR_STATUS, 8'hFF);
      rd(dpt_pkg::DPT_ADDR_STATUS, 8'h70);
      chk(32'(trim_o), 32'h9999);
      $display("test unmapped and read-only done");
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      summarize();
   end
endmodule // dpll_damping_and_freq_trim_test
`default_nettype wire
